// *** rtl/jbs_pkg.sv ***
// jbs_pkg: constants, types and decode helpers for the boundary-scan test port
// assumes: the tap logic runs on the test clock and the pad logic on mclk
package jbs_pkg;

  localparam int N_IO = 4;
  localparam int CELLS_PER_IO = 3;
  localparam int N_CELL = N_IO * CELLS_PER_IO;
  localparam int IR_W = 8;
  localparam int ID_W = 32;
  localparam int TLR_TMS_CNT = 5;

  // cell slot within one io group
  localparam int CELL_IN = 0;
  localparam int CELL_OUT = 1;
  localparam int CELL_OE = 2;

  localparam logic [IR_W-1:0] OP_EXTEST = 8'h00;
  localparam logic [IR_W-1:0] OP_SAMPLE = 8'h01;
  localparam logic [IR_W-1:0] OP_CLAMP = 8'h05;
  localparam logic [IR_W-1:0] OP_HIGHZ = 8'h07;
  localparam logic [IR_W-1:0] OP_USERCODE = 8'h0E;
  localparam logic [IR_W-1:0] OP_IDCODE = 8'h0F;
  localparam logic [IR_W-1:0] OP_BYPASS = 8'hFF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
  localparam logic [IR_W-1:0] IR_RESET = OP_IDCODE;

  // identification fields; values are arbitrary
  localparam logic [10:0] ID_MAKER = 11'h2A5;
  localparam logic [15:0] ID_PART = 16'h5A3C;
  localparam logic [3:0] ID_VERSION = 4'h1;
  localparam logic [ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  localparam logic [ID_W-1:0] USERCODE_VALUE = 32'h0000_0001;

  typedef enum logic [3:0] {
    ST_EX2DR = 4'h0,
    ST_EX1DR = 4'h1,
    ST_SHDR = 4'h2,
    ST_PDR = 4'h3,
    ST_SELIR = 4'h4,
    ST_UPDR = 4'h5,
    ST_CAPDR = 4'h6,
    ST_SELDR = 4'h7,
    ST_EX2IR = 4'h8,
    ST_EX1IR = 4'h9,
    ST_SHIR = 4'hA,
    ST_PIR = 4'hB,
    ST_RTI = 4'hC,
    ST_UPIR = 4'hD,
    ST_CAPIR = 4'hE,
    ST_TLR = 4'hF
  } jbs_state_e;

  typedef enum logic [1:0] {
    PATH_BYP = 2'h0,
    PATH_ID = 2'h1,
    PATH_USR = 2'h2,
    PATH_BSR = 2'h3
  } jbs_path_e;

  typedef struct packed {
    logic [N_IO-1:0] out;
    logic [N_IO-1:0] oe;
  } jbs_pad_s;

  typedef struct packed {
    logic extest;
    logic clamp;
    logic highz;
  } jbs_mode_s;

  function automatic jbs_path_e jbs_path(input logic [IR_W-1:0] ir);
    jbs_path_e p;
    p = PATH_BYP;
    if (ir == OP_EXTEST || ir == OP_SAMPLE) begin
      p = PATH_BSR;
    end else if (ir == OP_IDCODE) begin
      p = PATH_ID;
    end else if (ir == OP_USERCODE) begin
      p = PATH_USR;
    end
    return p;
  endfunction

endpackage

// *** rtl/jbs_tap.sv ***
// jbs_tap: test access port, instruction/data registers and pad boundary cells
// assumes: tck/tms/tdi/trst_n come from an external tester; pads and core on mclk
`timescale 1ns/1ps
`default_nettype none
module jbs_tap
  import jbs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  input wire logic freeze,
  input wire jbs_pad_s core_o,
  output logic [N_IO-1:0] core_in,
  input wire logic [N_IO-1:0] pad_in,
  output jbs_pad_s pad_o
);

  ////////////////////////////////////////////////////////////////////////////
  // reset sources for the test clock domain

  logic por_q;
  logic tap_arst;

  always_ff @(posedge mclk) begin
    por_q <= rst;
  end

  // async tap reset
  // power-up reset reaches the tap even with tck stopped
  assign tap_arst = !trst_n || por_q;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers, test clock side

  logic frz_s1_q;
  logic frz_s2_q;
  logic [N_IO-1:0] padin_t1_q;
  logic [N_IO-1:0] padin_t2_q;
  jbs_pad_s core_t1_q;
  jbs_pad_s core_t2_q;

  always_ff @(posedge tck or posedge tap_arst) begin
    if (tap_arst) begin
      frz_s1_q <= 1'b0;
      frz_s2_q <= 1'b0;
      padin_t1_q <= '0;
      padin_t2_q <= '0;
      core_t1_q <= '0;
      core_t2_q <= '0;
    end else begin
      frz_s1_q <= freeze;
      frz_s2_q <= frz_s1_q;
      padin_t1_q <= pad_in;
      padin_t2_q <= padin_t1_q;
      core_t1_q <= core_o;
      core_t2_q <= core_t1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // controller

  jbs_state_e state_q;
  jbs_state_e state_d;

  always_comb begin
    unique case (state_q)
      ST_TLR: state_d = tms ? ST_TLR : ST_RTI;
      ST_RTI: state_d = tms ? ST_SELDR : ST_RTI;
      ST_SELDR: state_d = tms ? ST_SELIR : ST_CAPDR;
      ST_CAPDR: state_d = tms ? ST_EX1DR : ST_SHDR;
      ST_SHDR: state_d = tms ? ST_EX1DR : ST_SHDR;
      ST_EX1DR: state_d = tms ? ST_UPDR : ST_PDR;
      ST_PDR: state_d = tms ? ST_EX2DR : ST_PDR;
      ST_EX2DR: state_d = tms ? ST_UPDR : ST_SHDR;
      ST_UPDR: state_d = tms ? ST_SELDR : ST_RTI;
      ST_SELIR: state_d = tms ? ST_TLR : ST_CAPIR;
      ST_CAPIR: state_d = tms ? ST_EX1IR : ST_SHIR;
      ST_SHIR: state_d = tms ? ST_EX1IR : ST_SHIR;
      ST_EX1IR: state_d = tms ? ST_UPIR : ST_PIR;
      ST_PIR: state_d = tms ? ST_EX2IR : ST_PIR;
      ST_EX2IR: state_d = tms ? ST_UPIR : ST_SHIR;
      ST_UPIR: state_d = tms ? ST_SELDR : ST_RTI;
    endcase
  end

  always_ff @(posedge tck or posedge tap_arst) begin
    if (tap_arst) begin
      state_q <= ST_TLR;
    end else if (frz_s2_q) begin
      state_q <= ST_TLR;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction register and mode

  logic [IR_W-1:0] ir_sh_q;
  logic [IR_W-1:0] ir_q;
  jbs_mode_s mode_q;
  jbs_path_e path;

  always_ff @(posedge tck or posedge tap_arst) begin
    if (tap_arst) begin
      ir_sh_q <= IR_CAPTURE;
      ir_q <= IR_RESET;
      mode_q <= '0;
    end else if (state_q == ST_TLR) begin
      ir_q <= IR_RESET;
      mode_q <= '0;
    end else if (state_q == ST_CAPIR) begin
      ir_sh_q <= IR_CAPTURE;
    end else if (state_q == ST_SHIR) begin
      ir_sh_q <= {tdi, ir_sh_q[IR_W-1:1]};
    end else if (state_q == ST_UPIR) begin
      ir_q <= ir_sh_q;
      mode_q.extest <= (ir_sh_q == OP_EXTEST);
      mode_q.clamp <= (ir_sh_q == OP_CLAMP);
      mode_q.highz <= (ir_sh_q == OP_HIGHZ);
    end
  end

  assign path = jbs_path(ir_q);

  ////////////////////////////////////////////////////////////////////////////
  // data registers

  logic bypass_q;
  logic [ID_W-1:0] id_sh_q;
  logic [N_CELL-1:0] bsr_sh_q;
  logic [N_CELL-1:0] bsr_upd_q;
  logic [N_CELL-1:0] bsr_cap;
  logic upd_tgl_q;

  for (genvar i = 0; i < N_IO; i++) begin : g_cap
    assign bsr_cap[CELLS_PER_IO*i+CELL_IN] = padin_t2_q[i];
    assign bsr_cap[CELLS_PER_IO*i+CELL_OUT] = core_t2_q.out[i];
    assign bsr_cap[CELLS_PER_IO*i+CELL_OE] = core_t2_q.oe[i];
  end

  always_ff @(posedge tck or posedge tap_arst) begin
    if (tap_arst) begin
      bypass_q <= 1'b0;
      id_sh_q <= '0;
      bsr_sh_q <= '0;
    end else if (state_q == ST_CAPDR) begin
      bypass_q <= 1'b0;
      id_sh_q <= (path == PATH_USR) ? USERCODE_VALUE : ID_VALUE;
      bsr_sh_q <= bsr_cap;
    end else if (state_q == ST_SHDR) begin
      bypass_q <= tdi;
      id_sh_q <= {tdi, id_sh_q[ID_W-1:1]};
      if (path == PATH_BSR) begin
        bsr_sh_q <= {tdi, bsr_sh_q[N_CELL-1:1]};
      end
    end
  end

  // update latches only move under extest or sample/preload
  always_ff @(posedge tck or posedge tap_arst) begin
    if (tap_arst) begin
      bsr_upd_q <= '0;
      upd_tgl_q <= 1'b0;
    end else if (state_q == ST_UPDR && path == PATH_BSR) begin
      bsr_upd_q <= bsr_sh_q;
      upd_tgl_q <= !upd_tgl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output on the falling edge

  logic tdo_q;
  logic tdo_oe_q;
  logic dr_bit;

  always_comb begin
    unique case (path)
      PATH_BYP: dr_bit = bypass_q;
      PATH_ID: dr_bit = id_sh_q[0];
      PATH_USR: dr_bit = id_sh_q[0];
      PATH_BSR: dr_bit = bsr_sh_q[0];
    endcase
  end

  always_ff @(negedge tck or posedge tap_arst) begin
    if (tap_arst) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q <= (state_q == ST_SHIR) ? ir_sh_q[0] : dr_bit;
      tdo_oe_q <= (state_q == ST_SHIR) || (state_q == ST_SHDR);
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // pad side on mclk

  jbs_mode_s mode_m1_q;
  jbs_mode_s mode_m2_q;
  jbs_mode_s mode_m3_q;
  jbs_mode_s mode_v_q;
  logic tgl_m1_q;
  logic tgl_m2_q;
  logic tgl_m3_q;
  logic [N_CELL-1:0] upd_m_q;
  logic [N_IO-1:0] padin_m1_q;
  logic [N_IO-1:0] padin_m2_q;
  logic [N_IO-1:0] upd_in;
  logic [N_IO-1:0] upd_out;
  logic [N_IO-1:0] upd_oe;
  logic drive_upd;

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_m1_q <= '0;
      mode_m2_q <= '0;
      mode_m3_q <= '0;
      mode_v_q <= '0;
      tgl_m1_q <= 1'b0;
      tgl_m2_q <= 1'b0;
      tgl_m3_q <= 1'b0;
      padin_m1_q <= '0;
      padin_m2_q <= '0;
    end else begin
      mode_m1_q <= mode_q;
      mode_m2_q <= mode_m1_q;
      mode_m3_q <= mode_m2_q;
      // multi-bit mode word: taken only once two samples agree, never half changed
      if (mode_m2_q == mode_m3_q) begin
        mode_v_q <= mode_m3_q;
      end
      tgl_m1_q <= upd_tgl_q;
      tgl_m2_q <= tgl_m1_q;
      tgl_m3_q <= tgl_m2_q;
      padin_m1_q <= pad_in;
      padin_m2_q <= padin_m1_q;
    end
  end

  // bus is sampled after the toggle settles; it holds until the next update-dr under extest or sample/preload
  always_ff @(posedge mclk) begin
    if (rst) begin
      upd_m_q <= '0;
    end else if (tgl_m2_q != tgl_m3_q) begin
      upd_m_q <= bsr_upd_q;
    end
  end

  for (genvar i = 0; i < N_IO; i++) begin : g_upd
    assign upd_in[i] = upd_m_q[CELLS_PER_IO*i+CELL_IN];
    assign upd_out[i] = upd_m_q[CELLS_PER_IO*i+CELL_OUT];
    assign upd_oe[i] = upd_m_q[CELLS_PER_IO*i+CELL_OE];
  end

  assign drive_upd = mode_v_q.extest || mode_v_q.clamp;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pad_o <= '0;
      core_in <= '0;
    end else begin
      pad_o.out <= drive_upd ? upd_out : core_o.out;
      pad_o.oe <= mode_v_q.highz ? '0 : (drive_upd ? upd_oe : core_o.oe);
      core_in <= mode_v_q.extest ? upd_in : padin_m2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [2:0] tms_run_q;

  always_ff @(posedge tck or posedge tap_arst) begin
    if (tap_arst) begin
      tms_run_q <= 3'h0;
    end else if (!tms) begin
      tms_run_q <= 3'h0;
    end else if (tms_run_q != 3'h7) begin
      tms_run_q <= tms_run_q + 3'h1;
    end
  end

  property p_tms_five;
    @(posedge tck) disable iff (tap_arst) tms_run_q >= 3'h5 |-> state_q == ST_TLR;
  endproperty
  a_tms_five: assert property (p_tms_five) else $error("no reset after five tms high");

  property p_arst_tlr;
    @(posedge tck) tap_arst |-> state_q == ST_TLR && ir_q == IR_RESET;
  endproperty
  a_arst_tlr: assert property (p_arst_tlr) else $error("reset did not reach tlr");

  property p_idle_walk;
    @(posedge tck) disable iff (tap_arst || frz_s2_q)
      (state_q == ST_TLR && !tms) ##1 (!tms) |=> state_q == ST_RTI;
  endproperty
  a_idle_walk: assert property (p_idle_walk) else $error("tms walk to idle wrong");

  property p_ir_update;
    @(posedge tck) disable iff (tap_arst || frz_s2_q)
      state_q == ST_UPIR |=> ir_q == $past(ir_sh_q);
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("ir not updated");

  property p_highz_mode;
    @(posedge tck) disable iff (tap_arst || frz_s2_q)
      state_q == ST_UPIR && ir_sh_q == OP_HIGHZ |=> mode_q.highz && !mode_q.extest;
  endproperty
  a_highz_mode: assert property (p_highz_mode) else $error("highz not decoded");

  property p_id_capture;
    @(posedge tck) disable iff (tap_arst || frz_s2_q)
      state_q == ST_CAPDR && ir_q == OP_IDCODE |=> id_sh_q == ID_VALUE && id_sh_q[0];
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("idcode capture wrong");

  property p_bsr_shift;
    @(posedge tck) disable iff (tap_arst || frz_s2_q)
      state_q == ST_SHDR && ir_q == OP_SAMPLE
      |=> bsr_sh_q == {$past(tdi), $past(bsr_sh_q[N_CELL-1:1])};
  endproperty
  a_bsr_shift: assert property (p_bsr_shift) else $error("chain shift wrong");

  property p_bypass_cap;
    @(posedge tck) disable iff (tap_arst || frz_s2_q)
      state_q == ST_CAPDR && ir_q == OP_BYPASS |=> !bypass_q;
  endproperty
  a_bypass_cap: assert property (p_bypass_cap) else $error("bypass capture not zero");

  property p_freeze;
    @(posedge tck) disable iff (tap_arst) frz_s2_q |=> state_q == ST_TLR;
  endproperty
  a_freeze: assert property (p_freeze) else $error("access during freeze");

  property p_extest_pad;
    @(posedge mclk) disable iff (rst)
      mode_v_q.extest && !mode_v_q.highz |=> pad_o.out == $past(upd_out);
  endproperty
  a_extest_pad: assert property (p_extest_pad) else $error("extest pad mismatch");

  c_shift_ir: cover property (@(posedge tck) state_q == ST_SHIR ##1 state_q == ST_EX1IR);
  c_id_read: cover property (@(posedge tck) state_q == ST_SHDR && path == PATH_ID);
  c_extest: cover property (@(posedge mclk) mode_v_q.extest && tgl_m2_q != tgl_m3_q);

endmodule
`default_nettype wire

// *** verif/jbs_tester.sv ***
// jbs_tester: behavioural boundary-scan tester driving the test port pins
// assumes: tck stands low between operations; tms and tdi idle high (pull-ups)
`timescale 1ns/1ps
`default_nettype none
module jbs_tester
  import jbs_pkg::*;
(
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  localparam realtime HALF = 62.5;
  logic oe_all;
  logic oe_last;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b1;
    oe_all = 1'b1;
    oe_last = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // tms set half period ahead
  // tdo is taken just before the rising edge, after the falling edge updated it
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #(HALF);
    q = tdo;
    oe_last = tdo_oe;
    tck = 1'b1;
    #(HALF);
    tck = 1'b0;
  endtask

  task automatic go(input logic [7:0] seq, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      step(seq[i], 1'b1, q);
    end
  endtask

  // serial unit, lsb first, tms high on the last bit
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    logic q;
    dout = '0;
    oe_all = 1'b1;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
      oe_all = oe_all & oe_last;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic ir(input logic [IR_W-1:0] op, output logic [IR_W-1:0] cap);
    logic [31:0] o;
    go(8'h03, 4);
    shift(IR_W, {24'h0, op}, o);
    cap = o[IR_W-1:0];
    go(8'h01, 2);
  endtask

  task automatic dr(input int n, input logic [31:0] din, output logic [31:0] dout);
    go(8'h01, 3);
    shift(n, din, dout);
    go(8'h01, 2);
  endtask

  task automatic reset5();
    go(8'h1F, 5);
  endtask

  // tck keeps running with tms low while test reset is held
  task automatic pulse_trst();
    trst_n = 1'b0;
    #100;
    go(8'h00, 2);
    trst_n = 1'b1;
    #100;
  endtask
endmodule
`default_nettype wire

// *** verif/jbs_tap_tb_top.sv ***
// jbs_tap_tb_top: scenario bench for the boundary-scan test port
// assumes: jbs_tester drives the test pins; core side driven here on mclk
`timescale 1ns/1ps
`default_nettype none
module jbs_tap_tb_top
  import jbs_pkg::*;
;
  logic mclk, rst, freeze, tck, tms, tdi, trst_n, tdo, tdo_oe;
  jbs_pad_s core_o, pad_o;
  logic [N_IO-1:0] core_in, pad_in;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] d;
  logic [IR_W-1:0] cap;

  jbs_tap dut (.mclk(mclk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe), .freeze(freeze), .core_o(core_o), .core_in(core_in),
    .pad_in(pad_in), .pad_o(pad_o));
  jbs_tester tst (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe));

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    freeze = 1'b0;
    core_o = '0;
    pad_in = '0;
  end
  always #2 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_ser(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t serial got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pad(input logic [2*N_IO-1:0] got, input logic [2*N_IO-1:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t pad got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] cells(input logic [N_IO-1:0] a, b, c);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < N_IO; i++) begin
      r[3*i+CELL_IN] = a[i];
      r[3*i+CELL_OUT] = b[i];
      r[3*i+CELL_OE] = c[i];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power_up();
    // two idle edges so the walk to run-test-idle is exercised
    tst.go(8'h00, 2);
    tst.dr(ID_W, 32'hFFFF_FFFF, d);
    chk_ser(d, ID_VALUE);
    chk_ser({31'h0, tst.oe_all}, 32'h1);
    $display("test power_up done");
  endtask

  task automatic t_codes();
    tst.ir(OP_USERCODE, cap);
    tst.dr(ID_W, 32'h0, d);
    chk_ser(d, USERCODE_VALUE);
    tst.ir(OP_IDCODE, cap);
    tst.dr(ID_W, 32'h0, d);
    chk_ser(d, ID_VALUE);
    $display("test codes done");
  endtask

  task automatic t_sample();
    @(posedge mclk);
    pad_in <= 4'hA;
    core_o <= '{out: 4'h5, oe: 4'hC};
    tst.ir(OP_SAMPLE, cap);
    chk_ser({24'h0, cap}, {24'h0, IR_CAPTURE});
    tst.dr(N_CELL, cells(4'h6, 4'h9, 4'hE), d);
    chk_ser(d, cells(4'hA, 4'h5, 4'hC));
    repeat (4) @(posedge mclk);
    chk_pad(pad_o, {4'h5, 4'hC});
    chk_pad({4'h0, core_in}, {4'h0, 4'hA});
    $display("test sample done");
  endtask

  task automatic t_extest();
    tst.ir(OP_EXTEST, cap);
    repeat (4) @(posedge mclk);
    chk_pad(pad_o, {4'h9, 4'hE});
    chk_pad({4'h0, core_in}, {4'h0, 4'h6});
    tst.dr(N_CELL, cells(4'h6, 4'h9, 4'hE), d);
    chk_ser(d, cells(4'hA, 4'h5, 4'hC));
    $display("test extest done");
  endtask

  task automatic t_bypass();
    logic [IR_W-1:0] ops [4];
    ops = '{OP_CLAMP, OP_HIGHZ, 8'h3C, OP_BYPASS};
    for (int k = 0; k < 4; k++) begin
      tst.ir(ops[k], cap);
      tst.dr(8, 32'h96, d);
      chk_ser(d, 32'h2C);
      repeat (4) @(posedge mclk);
      if (k == 0) chk_pad(pad_o, {4'h9, 4'hE});
      if (k == 1) chk_pad({4'h0, pad_o.oe}, 8'h00);
      if (k == 3) chk_pad(pad_o, {4'h5, 4'hC});
    end
    $display("test bypass done");
  endtask

  task automatic t_tms_reset();
    tst.ir(OP_BYPASS, cap);
    tst.go(8'h03, 4);
    tst.reset5();
    tst.go(8'h00, 1);
    tst.dr(ID_W, 32'h0, d);
    chk_ser(d, ID_VALUE);
    $display("test tms_reset done");
  endtask

  task automatic t_trst();
    tst.ir(OP_BYPASS, cap);
    tst.pulse_trst();
    tst.go(8'h00, 1);
    tst.dr(ID_W, 32'h0, d);
    chk_ser(d, ID_VALUE);
    $display("test trst done");
  endtask

  task automatic t_freeze();
    @(posedge mclk);
    freeze <= 1'b1;
    tst.go(8'h01, 3);
    tst.ir(OP_BYPASS, cap);
    chk_ser({31'h0, tst.oe_all}, 32'h0);
    @(posedge mclk);
    freeze <= 1'b0;
    tst.reset5();
    tst.go(8'h00, 1);
    tst.dr(ID_W, 32'h0, d);
    chk_ser(d, ID_VALUE);
    $display("test freeze done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // whole run is about 61 us of test clock traffic
  initial begin
    #300000;
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    t_power_up();
    t_codes();
    t_sample();
    t_extest();
    t_bypass();
    t_tms_reset();
    t_trst();
    t_freeze();
    give_verdict();
  end
endmodule
`default_nettype wire
